/* File: rtl/fspr_device.sv */
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - Rows of 32 fourteen-bit words; row erase minimum
// - Thirty-two hidden latches filled through data pair
// - Firmware loads address, clears config select, reads
// - Array read in second cycle; second slot discarded
// - Read data in pair the cycle after
// - Data pair holds until read or write
// - Firmware puts two NOPs after read trigger
// - Erase, load, program only after unlock
// - Firmware writes 55h, AAh, trigger, two NOPs
// - Write trigger forces next two slots NOP
// - Erase or program stalls about 2 ms
// - Latch load: two NOPs, no stall
// - Firmware masks interrupts around unlock; the core has no interrupts to mask
// - Erase any address in row; erase, enable set
// - Stall halts execution only; clocks run
// - Two setup cycles; resume at third instruction
// - Firmware puts two NOPs after erase trigger
// - Firmware saves row before rewriting programmed words; the core programs without saving the row
// - Triggers set by software, cleared by hardware
// - Write needs enable bit; cleared at reset
// - Fifteen-bit address pair, fourteen-bit data pair
// - Low five bits pick latch; upper ten row
module fspr_device #(
  parameter int LSEL_W       = fspr_pkg::LATCH_SEL_W,
  parameter int ERASE_CYCLES = fspr_pkg::ERASE_CYCLES
) (
  input  wire logic                                         clk,
  input  wire logic                                         rst_b,
  input  wire logic                                         ce,
  fspr_if.dev                                               bus,
  output wire logic [fspr_pkg::ADDR_W-1:0]                  mem_addr,
  output wire logic [fspr_pkg::ADDR_W-LSEL_W-1:0]           mem_row,
  output wire logic                                         mem_cfg,
  output wire logic                                         mem_rd,
  input  wire logic [fspr_pkg::DATA_W-1:0]                  mem_rdata,
  output wire logic                                         mem_erase,
  output wire logic                                         mem_prog,
  output wire logic [(1<<LSEL_W)*fspr_pkg::DATA_W-1:0]      mem_row_data
);
  import fspr_pkg::*;

  localparam int NWORDS = 1 << LSEL_W;
  localparam int TMR_W  = $clog2(ERASE_CYCLES + 1);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (LSEL_W < 1 || LSEL_W > 8) begin : g_bad_lsel
      $error("fspr_device: latch select must fit in the low address byte");
    end
    if (ERASE_CYCLES < 1) begin : g_bad_erase
      $error("fspr_device: erase time must be at least one cycle");
    end
  endgenerate

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RD1  = 6'b000010,
    ST_RD2  = 6'b000100,
    ST_WR1  = 6'b001000,
    ST_WR2  = 6'b010000,
    ST_BUSY = 6'b100000
  } fspr_state_t;

  typedef enum logic [2:0] {
    KEY_NONE = 3'b001,
    KEY_55   = 3'b010,
    KEY_AA   = 3'b100
  } fspr_key_t;

  typedef struct packed {
    fspr_state_t                      st;
    fspr_key_t                        key;
    logic                             rd;
    logic                             wr;
    logic                             write_enable_bit;
    logic                             erase;
    logic                             lwlo;
    logic                             config_space_select;
    logic [ADDR_W-1:0]                adr;
    logic [DATA_W-1:0]                dat;
    logic [NWORDS-1:0][DATA_W-1:0]    lat;
    logic [TMR_W-1:0]                 tmr;
    logic [7:0]                       rdata;
    logic                             mem_erase;
    logic                             mem_prog;
  } fspr_dev_t;

  localparam fspr_dev_t RST_VAL = '{st: ST_IDLE, key: KEY_NONE, lat: {NWORDS{LATCH_RESET}}, default: '0};

  function automatic logic sfr_hit(input logic en, input logic [2:0] a, input logic [2:0] target);
    sfr_hit = en && (a == target);
  endfunction : sfr_hit

  fspr_dev_t r;
  fspr_dev_t next_r;
  logic      stall;
  logic      kill;
  logic      take;

  // ----------------------------------------------------------------
  // Slot control
  // ----------------------------------------------------------------
  assign stall = (r.st == ST_BUSY);
  assign kill  = (r.st == ST_RD2) || (r.st == ST_WR1) || (r.st == ST_WR2);
  assign take  = bus.sfr_wr && !stall && !kill;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r           = r;
    next_r.mem_erase = 1'b0;
    next_r.mem_prog  = 1'b0;
    next_r.rdata     = 8'h00;

    // Register read answers one cycle later; the key register reads zero
    if (bus.sfr_rd && !stall && !kill) begin
      case (bus.sfr_addr)
        SFR_CTRL: next_r.rdata = {1'b0, r.config_space_select, r.lwlo, r.erase, 1'b0, r.write_enable_bit, r.wr, r.rd};
        SFR_DATL: next_r.rdata = r.dat[7:0];
        SFR_DATH: next_r.rdata = {2'b00, r.dat[DATA_W-1:8]};
        SFR_ADRL: next_r.rdata = r.adr[7:0];
        SFR_ADRH: next_r.rdata = {1'b0, r.adr[ADDR_W-1:8]};
        default:  next_r.rdata = 8'h00;
      endcase
    end

    // Any taken write that is not the next unlock step drops the unlock
    if (take) begin
      next_r.key = KEY_NONE;
    end

    if (sfr_hit(take, bus.sfr_addr, SFR_KEY)) begin
      if (bus.sfr_wdata == KEY_FIRST) begin
        next_r.key = KEY_55;
      end else if (bus.sfr_wdata == KEY_SECOND && r.key == KEY_55) begin
        next_r.key = KEY_AA;
      end
    end

    if (sfr_hit(take, bus.sfr_addr, SFR_DATL)) begin
      next_r.dat[7:0] = bus.sfr_wdata;
    end
    if (sfr_hit(take, bus.sfr_addr, SFR_DATH)) begin
      next_r.dat[DATA_W-1:8] = bus.sfr_wdata[DATA_W-9:0];
    end
    if (sfr_hit(take, bus.sfr_addr, SFR_ADRL)) begin
      next_r.adr[7:0] = bus.sfr_wdata;
    end
    if (sfr_hit(take, bus.sfr_addr, SFR_ADRH)) begin
      next_r.adr[ADDR_W-1:8] = bus.sfr_wdata[ADDR_W-9:0];
    end

    if (sfr_hit(take, bus.sfr_addr, SFR_CTRL)) begin
      next_r.write_enable_bit  = bus.sfr_wdata[CTRL_WRITE_ENABLE_BIT];
      next_r.erase = bus.sfr_wdata[CTRL_ERASE];
      next_r.lwlo  = bus.sfr_wdata[CTRL_LWLO];
      next_r.config_space_select  = bus.sfr_wdata[CTRL_CONFIG_SPACE_SELECT];
      // Trigger bits only set here; a written zero leaves them alone
      if (r.st == ST_IDLE && bus.sfr_wdata[CTRL_RD]) begin
        next_r.rd = 1'b1;
        next_r.st = ST_RD1;
      end else if (r.st == ST_IDLE && bus.sfr_wdata[CTRL_WR] && bus.sfr_wdata[CTRL_WRITE_ENABLE_BIT]
                   && r.key == KEY_AA) begin
        next_r.wr = 1'b1;
        next_r.st = ST_WR1;
      end
    end

    case (r.st)
      ST_IDLE: begin
      end
      ST_RD1: begin
        next_r.st = ST_RD2;
      end
      ST_RD2: begin
        next_r.dat = mem_rdata;
        next_r.rd  = 1'b0;
        next_r.st  = ST_IDLE;
      end
      ST_WR1: begin
        // First forced slot: the word goes into its latch unless erasing
        if (!r.erase) begin
          next_r.lat[r.adr[LSEL_W-1:0]] = r.dat;
        end
        next_r.st = ST_WR2;
      end
      ST_WR2: begin
        if (r.erase || !r.lwlo) begin
          next_r.mem_erase = r.erase;
          next_r.mem_prog  = !r.erase;
          next_r.tmr       = TMR_W'(ERASE_CYCLES - 1);
          next_r.st        = ST_BUSY;
        end else begin
          next_r.wr = 1'b0;
          next_r.st = ST_IDLE;
        end
      end
      ST_BUSY: begin
        // Only instruction flow halts; this block keeps clocking
        if (r.tmr == '0) begin
          next_r.wr = 1'b0;
          next_r.st = ST_IDLE;
          if (!r.erase) begin
            next_r.lat = {NWORDS{LATCH_RESET}};
          end
        end else begin
          next_r.tmr = r.tmr - TMR_W'(1);
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= RST_VAL;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.sfr_rdata = r.rdata;
  assign bus.force_nop = kill;
  assign bus.stall     = stall;
  assign mem_addr      = r.adr;
  assign mem_row       = r.adr[ADDR_W-1:LSEL_W];
  assign mem_cfg       = r.config_space_select;
  assign mem_rd        = (r.st == ST_RD2);
  assign mem_erase     = r.mem_erase;
  assign mem_prog      = r.mem_prog;
  assign mem_row_data  = r.lat;
endmodule : fspr_device

/* File: rtl/fspr_pkg.sv */
package fspr_pkg;
  // ----------------------------------------------------------------
  // Word and address geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 15;
  localparam int          DATA_W      = 14;
  localparam int          SFR_AW      = 3;
  localparam int          LATCH_SEL_W = 5;
  localparam int          ROW_WORDS   = 32;
  localparam logic [13:0] LATCH_RESET = 14'h3fff;

  // ----------------------------------------------------------------
  // Controller register indices and control bit positions
  // ----------------------------------------------------------------
  localparam logic [2:0] SFR_CTRL = 3'h0;
  localparam logic [2:0] SFR_KEY  = 3'h1;
  localparam logic [2:0] SFR_DATL = 3'h2;
  localparam logic [2:0] SFR_DATH = 3'h3;
  localparam logic [2:0] SFR_ADRL = 3'h4;
  localparam logic [2:0] SFR_ADRH = 3'h5;

  localparam int CTRL_RD    = 0;
  localparam int CTRL_WR    = 1;
  localparam int CTRL_WRITE_ENABLE_BIT  = 2;
  localparam int CTRL_ERASE = 4;
  localparam int CTRL_LWLO  = 5;
  localparam int CTRL_CONFIG_SPACE_SELECT  = 6;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int ERASE_TIME_MS = 2;
  localparam int ERASE_CYCLES  = ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Core-side command registers, operations and step kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] HREG_CMD  = 2'h0;
  localparam logic [1:0] HREG_ADDR = 2'h1;
  localparam logic [1:0] HREG_DATA = 2'h2;
  localparam logic [1:0] HREG_STAT = 2'h3;

  localparam logic [2:0] OP_READ  = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_LOAD  = 3'h3;
  localparam logic [2:0] OP_PROG  = 3'h4;

  localparam logic [1:0] K_WR  = 2'h0;
  localparam logic [1:0] K_RD  = 2'h1;
  localparam logic [1:0] K_NOP = 2'h2;
  localparam logic [1:0] K_END = 2'h3;
endpackage : fspr_pkg

/* File: rtl/fspr_if.sv */
`timescale 1ns/10ps
interface fspr_if;
  logic [fspr_pkg::SFR_AW-1:0] sfr_addr;
  logic [7:0]                  sfr_wdata;
  logic                        sfr_wr;
  logic                        sfr_rd;
  logic [7:0]                  sfr_rdata;
  logic                        force_nop;
  logic                        stall;

  modport dev (
    input  sfr_addr,
    input  sfr_wdata,
    input  sfr_wr,
    input  sfr_rd,
    output sfr_rdata,
    output force_nop,
    output stall
  );

  modport core (
    output sfr_addr,
    output sfr_wdata,
    output sfr_wr,
    output sfr_rd,
    input  sfr_rdata,
    input  force_nop,
    input  stall
  );
endinterface : fspr_if

/* File: rtl/fspr_core.sv */
`timescale 1ns/10ps
module fspr_core (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        ce,
  fspr_if.core                             bus,
  input  wire logic [1:0]                  u_addr,
  input  wire logic [15:0]                 u_wdata,
  input  wire logic                        u_wr,
  input  wire logic                        u_rd,
  output wire logic [15:0]                 u_rdata
);
  import fspr_pkg::*;

  typedef struct packed {
    logic              busy;
    logic [2:0]        op;
    logic [3:0]        step;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] result;
    logic [2:0]        sfr_addr;
    logic [7:0]        sfr_wdata;
    logic              sfr_wr;
    logic              sfr_rd;
    logic [1:0]        cap;
    logic [15:0]       u_rdata;
  } fspr_core_t;

  // ----------------------------------------------------------------
  // Instruction sequences: {kind, register, byte}
  // ----------------------------------------------------------------
  function automatic logic [12:0] seq_step(input logic [2:0] op, input logic [3:0] idx,
                                           input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [7:0] mode;
    mode = 8'h00;
    mode[CTRL_WRITE_ENABLE_BIT]  = 1'b1;
    mode[CTRL_ERASE] = (op == OP_ERASE);
    mode[CTRL_LWLO]  = (op == OP_LOAD);
    if (op == OP_READ) begin
      case (idx)
        4'h0:    seq_step = {K_WR, SFR_ADRL, a[7:0]};
        4'h1:    seq_step = {K_WR, SFR_ADRH, 1'b0, a[14:8]};
        4'h2:    seq_step = {K_WR, SFR_CTRL, 8'h00};
        4'h3:    seq_step = {K_WR, SFR_CTRL, 8'h01 << CTRL_RD};
        4'h4:    seq_step = {K_NOP, 3'h0, 8'h00};
        4'h5:    seq_step = {K_NOP, 3'h0, 8'h00};
        4'h6:    seq_step = {K_RD, SFR_DATL, 8'h00};
        4'h7:    seq_step = {K_RD, SFR_DATH, 8'h00};
        default: seq_step = {K_END, 3'h0, 8'h00};
      endcase
    end else begin
      case (idx)
        4'h0:    seq_step = {K_WR, SFR_ADRL, a[7:0]};
        4'h1:    seq_step = {K_WR, SFR_ADRH, 1'b0, a[14:8]};
        4'h2:    seq_step = {K_WR, SFR_DATL, d[7:0]};
        4'h3:    seq_step = {K_WR, SFR_DATH, 2'b00, d[13:8]};
        4'h4:    seq_step = {K_WR, SFR_CTRL, mode};
        4'h5:    seq_step = {K_WR, SFR_KEY, KEY_FIRST};
        4'h6:    seq_step = {K_WR, SFR_KEY, KEY_SECOND};
        4'h7:    seq_step = {K_WR, SFR_CTRL, mode | (8'h01 << CTRL_WR)};
        4'h8:    seq_step = {K_NOP, 3'h0, 8'h00};
        4'h9:    seq_step = {K_NOP, 3'h0, 8'h00};
        4'ha:    seq_step = {K_WR, SFR_CTRL, 8'h00};
        default: seq_step = {K_END, 3'h0, 8'h00};
      endcase
    end
  endfunction : seq_step

  fspr_core_t  r;
  fspr_core_t  next_r;
  logic [12:0] s;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r         = r;
    next_r.u_rdata = 16'h0000;
    next_r.cap     = 2'b00;
    s              = seq_step(r.op, r.step, r.addr, r.data);

    if (u_rd) begin
      case (u_addr)
        HREG_CMD:  next_r.u_rdata = {13'h0000, r.op};
        HREG_ADDR: next_r.u_rdata = {1'b0, r.addr};
        HREG_DATA: next_r.u_rdata = {2'b00, r.result};
        default:   next_r.u_rdata = {15'h0000, r.busy};
      endcase
    end

    // Commands are refused while a sequence runs
    if (u_wr && !r.busy) begin
      case (u_addr)
        HREG_ADDR: next_r.addr = u_wdata[ADDR_W-1:0];
        HREG_DATA: next_r.data = u_wdata[DATA_W-1:0];
        HREG_CMD: begin
          if (u_wdata[2:0] >= OP_READ && u_wdata[2:0] <= OP_PROG) begin
            next_r.busy = 1'b1;
            next_r.op   = u_wdata[2:0];
            next_r.step = 4'h0;
          end
        end
        default: begin
        end
      endcase
    end

    if (r.cap[0]) begin
      next_r.result[7:0] = bus.sfr_rdata;
    end
    if (r.cap[1]) begin
      next_r.result[DATA_W-1:8] = bus.sfr_rdata[DATA_W-9:0];
    end
    if (r.sfr_rd) begin
      next_r.cap = (r.sfr_addr == SFR_DATL) ? 2'b01 : 2'b10;
    end

    // A stalled instruction is held and retried, which resumes at the third slot
    if (!bus.stall) begin
      next_r.sfr_wr = 1'b0;
      next_r.sfr_rd = 1'b0;
      if (r.busy) begin
        if (s[12:11] == K_END) begin
          next_r.busy = 1'b0;
        end else begin
          next_r.sfr_wr    = (s[12:11] == K_WR);
          next_r.sfr_rd    = (s[12:11] == K_RD);
          next_r.sfr_addr  = s[10:8];
          next_r.sfr_wdata = s[7:0];
          next_r.step      = r.step + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign bus.sfr_addr  = r.sfr_addr;
  assign bus.sfr_wdata = r.sfr_wdata;
  assign bus.sfr_wr    = r.sfr_wr;
  assign bus.sfr_rd    = r.sfr_rd;
  assign u_rdata       = r.u_rdata;
endmodule : fspr_core

/* File: testbench/fspr_sva.sv */
`timescale 1ns/10ps
module fspr_sva #(
  parameter int ERASE_CYCLES = fspr_pkg::ERASE_CYCLES
) (
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic [fspr_pkg::SFR_AW-1:0] sfr_addr,
  input wire logic [7:0]                  sfr_wdata,
  input wire logic                        sfr_wr,
  input wire logic                        sfr_rd,
  input wire logic [7:0]                  sfr_rdata,
  input wire logic                        force_nop,
  input wire logic                        stall
);
  import fspr_pkg::*;
  logic        idle, key1, key2, trig, rd_go;
  logic [31:0] stall_n;
  assign idle  = !stall && !force_nop;
  assign key1  = sfr_wr && idle && sfr_addr == SFR_KEY && sfr_wdata == KEY_FIRST;
  assign key2  = sfr_wr && idle && sfr_addr == SFR_KEY && sfr_wdata == KEY_SECOND;
  assign trig  = sfr_wr && idle && sfr_addr == SFR_CTRL && sfr_wdata[CTRL_WR] && !sfr_wdata[CTRL_RD];
  assign rd_go = sfr_wr && idle && sfr_addr == SFR_CTRL && sfr_wdata[CTRL_RD];
  // Counter, so the stall length can stay a parameter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stall_n <= 32'h0;
    end else begin
      stall_n <= stall ? stall_n + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ------------------------------
  // Link timing
  // ------------------------------
  sequence s_unlock;
    key1 ##1 key2 ##1 trig;
  endsequence
  property p_rd_slot;
    rd_go |=> !force_nop ##1 force_nop ##1 !force_nop;
  endproperty
  a_rd_slot: assert property (p_rd_slot) else $error("read slot wrong");
  property p_unlock;
    s_unlock |=> force_nop ##1 force_nop ##1 !force_nop;
  endproperty
  a_unlock: assert property (p_unlock) else $error("no forced nops");
  property p_load;
    key1 ##1 key2 ##1 (trig && sfr_wdata[CTRL_LWLO] && !sfr_wdata[CTRL_ERASE]) |=> ##2 !stall;
  endproperty
  a_load: assert property (p_load) else $error("latch load stalled");
  property p_no_write_enable_bit;
    sfr_wr && idle && sfr_addr == SFR_CTRL && !sfr_wdata[CTRL_WRITE_ENABLE_BIT] && !sfr_wdata[CTRL_RD]
      |=> !force_nop ##1 !force_nop ##1 !stall;
  endproperty
  a_no_write_enable_bit: assert property (p_no_write_enable_bit) else $error("write without enable");
  property p_stall_src;
    $rose(stall) |-> $past(force_nop) && $past(force_nop, 2) && $past(trig, 3);
  endproperty
  a_stall_src: assert property (p_stall_src) else $error("stall start wrong");
  property p_stall_len;
    $fell(stall) |-> stall_n == ERASE_CYCLES;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_nop_max;
    force_nop ##1 force_nop |=> !force_nop;
  endproperty
  a_nop_max: assert property (p_nop_max) else $error("too many nops");
  property p_rdata_idle;
    !$past(sfr_rd) |-> sfr_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
  property p_stall_hold;
    stall && sfr_wr |=> sfr_wr && $stable(sfr_addr) && $stable(sfr_wdata);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("held write lost");
  c_read: cover property (rd_go);
  c_unlock: cover property (s_unlock);
  c_stall: cover property ($rose(stall));
endmodule : fspr_sva

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import fspr_pkg::*;
  localparam int ECYC = 8;
  typedef struct packed {
    logic [14:0] addr;
    logic [13:0] data;
  } fspr_row_t;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         ce = 1'b1;
  logic [1:0]   u_addr = 2'h0;
  logic [15:0]  u_wdata = 16'h0;
  logic         u_wr = 1'b0;
  logic         u_rd = 1'b0;
  logic [15:0]  u_rdata, v;
  logic [14:0]  mem_addr, mem_addr_b;
  logic [9:0]   mem_row, erase_row, prog_row;
  logic         mem_cfg, mem_erase, mem_prog, mem_erase_b, mem_rd;
  logic [447:0] mem_row_data, row_snap;
  int           n_mismatch = 0, compares = 0, n_erase = 0, n_prog = 0, n_stall = 0, n_erase_b = 0, cyc = 0;
  fspr_row_t    rows [4] = '{'{15'h0000, 14'h3fff}, '{15'h7fff, 14'h0000}, '{15'h1234, 14'h2dcb},
                             '{15'h4a5f, 14'h35a0}};
  fspr_if u_if ();
  fspr_if u_if_b ();
  fspr_device #(.ERASE_CYCLES(ECYC)) u_fspr_device (
    .clk(clk), .rst_b(rst_b), .ce(ce), .bus(u_if.dev), .mem_addr(mem_addr), .mem_row(mem_row), .mem_cfg(mem_cfg),
    .mem_rd(mem_rd), .mem_rdata(mem_rd ? ~mem_addr[13:0] : 14'h0000), .mem_erase(mem_erase),
    .mem_prog(mem_prog), .mem_row_data(mem_row_data));
  fspr_core u_fspr_core (
    .clk(clk), .rst_b(rst_b), .ce(ce), .bus(u_if.core), .u_addr(u_addr), .u_wdata(u_wdata), .u_wr(u_wr),
    .u_rd(u_rd), .u_rdata(u_rdata));
  // Driven by the bench itself, so broken key sequences can reach it
  fspr_device #(.ERASE_CYCLES(ECYC)) u_fspr_device_b (
    .clk(clk), .rst_b(rst_b), .ce(ce), .bus(u_if_b.dev), .mem_addr(mem_addr_b), .mem_row(), .mem_cfg(), .mem_rd(),
    .mem_rdata(~mem_addr_b[13:0]), .mem_erase(mem_erase_b), .mem_prog(), .mem_row_data());
  fspr_sva #(.ERASE_CYCLES(ECYC)) u_fspr_sva (
    .clk(clk), .rst_b(rst_b), .sfr_addr(u_if.sfr_addr), .sfr_wdata(u_if.sfr_wdata), .sfr_wr(u_if.sfr_wr),
    .sfr_rd(u_if.sfr_rd), .sfr_rdata(u_if.sfr_rdata), .force_nop(u_if.force_nop), .stall(u_if.stall));

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem_erase === 1'b1) begin
      n_erase <= n_erase + 1;
      erase_row <= mem_row;
    end
    if (mem_prog === 1'b1) begin
      n_prog <= n_prog + 1;
      prog_row <= mem_row;
      row_snap <= mem_row_data;
    end
    if (u_if.stall === 1'b1) n_stall <= n_stall + 1;
    if (mem_erase_b === 1'b1) n_erase_b <= n_erase_b + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic uw(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    u_addr <= a;
    u_wdata <= d;
    u_wr <= 1'b1;
    @(posedge clk);
    u_wr <= 1'b0;
  endtask : uw

  task automatic ur(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    u_addr <= a;
    u_rd <= 1'b1;
    @(posedge clk);
    u_rd <= 1'b0;
    #1 d = u_rdata;
  endtask : ur

  task automatic op(input logic [2:0] cmd, input logic [14:0] a, input logic [13:0] d);
    logic [15:0] st;
    uw(HREG_ADDR, {1'b0, a});
    uw(HREG_DATA, {2'b00, d});
    uw(HREG_CMD, {13'h0, cmd});
    for (int i = 0; i < 40; i++) begin
      ur(HREG_STAT, st);
      if (st[0] === 1'b0) break;
    end
    chk({15'h0, st[0]}, 16'h0, "busy stuck");
  endtask : op

  // Strobe stays high between writes; the key steps must be back to back
  task automatic dw(input logic [2:0] a, input logic [7:0] d);
    u_if_b.sfr_addr <= a;
    u_if_b.sfr_wdata <= d;
    u_if_b.sfr_wr <= 1'b1;
    @(posedge clk);
  endtask : dw

  task automatic dend;
    u_if_b.sfr_wr <= 1'b0;
    repeat (ECYC + 6) @(posedge clk);
  endtask : dend

  task automatic drc(input logic [2:0] a, input logic [7:0] e, input string what);
    u_if_b.sfr_addr <= a;
    u_if_b.sfr_wr <= 1'b0;
    u_if_b.sfr_rd <= 1'b1;
    @(posedge clk);
    u_if_b.sfr_rd <= 1'b0;
    #1 chk({8'h0, u_if_b.sfr_rdata}, {8'h0, e}, what);
  endtask : drc

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  initial begin
    u_if_b.sfr_addr = 3'h0;
    u_if_b.sfr_wdata = 8'h0;
    u_if_b.sfr_wr = 1'b0;
    u_if_b.sfr_rd = 1'b0;
    repeat (12) @(posedge clk);
    chk({15'h0, u_if.stall | u_if.force_nop}, 16'h0, "link busy in reset");
    chk({15'h0, mem_row_data === {32{LATCH_RESET}}}, 16'h1, "latches at reset");
    rst_b <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      op(OP_READ, rows[i].addr, 14'h0);
      ur(HREG_DATA, v);
      chk(v, {2'b00, rows[i].data}, "read word");
      chk({15'h0, mem_cfg}, 16'h0, "config space set");
    end
    $display("test reads done");
    op(OP_ERASE, 15'h1234, 14'h0);
    chk(16'(n_erase), 16'h1, "erase count");
    chk({6'h0, erase_row}, 16'h0091, "erase row");
    chk(16'(n_stall), 16'h0008, "erase stall");
    ur(HREG_ADDR, v);
    chk(v, 16'h1234, "address readback");
    ur(HREG_CMD, v);
    chk(v, {13'h0, OP_ERASE}, "command readback");
    // Unknown command code must not start a sequence
    uw(HREG_CMD, 16'h0007);
    ur(HREG_STAT, v);
    chk(v, 16'h0000, "bad command taken");
    $display("test erase done");
    op(OP_LOAD, 15'h0045, 14'h1abc);
    op(OP_LOAD, 15'h005f, 14'h0001);
    chk({2'b00, mem_row_data[5*14 +: 14]}, 16'h1abc, "latch 5");
    chk({2'b00, mem_row_data[31*14 +: 14]}, 16'h0001, "latch 31");
    chk(16'(n_stall), 16'h0008, "load stalled");
    op(OP_PROG, 15'h0040, 14'h2222);
    chk(16'(n_prog), 16'h1, "program count");
    chk({6'h0, prog_row}, 16'h0002, "program row");
    chk({2'b00, row_snap[13:0]}, 16'h2222, "latch 0 programmed");
    chk({2'b00, row_snap[5*14 +: 14]}, 16'h1abc, "latch 5 programmed");
    chk(16'(n_stall), 16'h0010, "program stall");
    chk({15'h0, mem_row_data === {32{LATCH_RESET}}}, 16'h1, "latches after program");
    $display("test program done");
    @(posedge clk);
    drc(SFR_CTRL, 8'h00, "control after reset");
    dw(SFR_ADRL, 8'h20);
    dw(SFR_ADRH, 8'h00);
    // Nonzero data first, so an executed second slot would show
    dw(SFR_DATL, 8'h5a);
    dw(SFR_CTRL, 8'h01);
    drc(SFR_ADRL, 8'h20, "first slot lost");
    drc(SFR_DATL, 8'h00, "slot not discarded");
    drc(SFR_DATL, 8'hdf, "data low");
    drc(SFR_DATH, 8'h3f, "data high");
    drc(SFR_CTRL, 8'h00, "read trigger kept");
    dw(SFR_DATL, 8'h5a);
    drc(SFR_DATL, 8'h5a, "data pair write");
    $display("test direct read done");
    dw(SFR_KEY, KEY_FIRST);
    dw(SFR_DATL, 8'h00);
    dw(SFR_KEY, KEY_SECOND);
    dw(SFR_CTRL, 8'h16);
    dend();
    chk(16'(n_erase_b), 16'h0, "erase after stray write");
    drc(SFR_KEY, 8'h00, "key readable");
    dw(SFR_KEY, KEY_FIRST);
    dw(SFR_KEY, KEY_SECOND);
    dw(SFR_CTRL, 8'h12);
    dend();
    chk(16'(n_erase_b), 16'h0, "erase without enable");
    dw(SFR_KEY, KEY_FIRST);
    dw(SFR_KEY, KEY_SECOND);
    dw(SFR_CTRL, 8'h16);
    dend();
    chk(16'(n_erase_b), 16'h1, "unlocked erase");
    chk({15'h0, u_if_b.stall}, 16'h0, "stall stuck");
    // A write offered while the enable is low must leave no trace
    ce <= 1'b0;
    dw(SFR_DATL, 8'h33);
    u_if_b.sfr_wr <= 1'b0;
    ce <= 1'b1;
    @(posedge clk);
    drc(SFR_DATL, 8'h00, "write while frozen");
    $display("test unlock done");
    wrap_up();
  end
endmodule : tb_top
